// >>> rtl/config_capability_chain.sv
// message, product-data and vendor capability registers with serial EEPROM engine
`timescale 1ns/1ps
module config_capability_chain
  import cap_chain_pkg::*;
#(
  parameter bit UPSTREAM = 1'b0,
  parameter int unsigned SCK_HALF = SCK_HALF_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  input wire logic irq_level,
  output logic intx_assert,
  output logic msi_valid,
  output logic [63:0] msi_addr,
  output logic [15:0] msi_data,
  input wire logic msi_ready,
  output logic ee_cs_n,
  output logic ee_sck,
  output logic ee_mosi,
  input wire logic ee_miso
);

  localparam logic [15:0] HALF_LAST = 16'(SCK_HALF - 1);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  logic sel_ctrl;
  logic sel_low;
  logic sel_high;
  logic sel_data;
  logic sel_cmd;
  logic sel_win;
  logic sel_vnd;
  logic wr;
  logic engine_busy;
  logic cmd_start;

  logic interrupt_message_permit;
  logic [2:0] msi_mme;
  logic [31:0] msi_low_target;
  logic [31:0] msi_high_target;
  logic [15:0] msi_payload;
  logic irq_prev;

  logic [5:0] table_dword_index;
  logic table_cycle_flag;
  logic [31:0] table_data_window;
  logic start_req;
  ee_state_e state;
  logic [15:0] phase;
  logic [5:0] bit_cnt;
  logic [47:0] tx_shift;
  logic [31:0] rx_shift;
  logic miso_s1;
  logic miso_s2;
  logic miso_s3;
  logic miso_clean;
  logic launch;
  logic half_done;
  logic sck_fall;
  logic last_fall;

  logic [31:0] next_rdata;

  // message registers appear only downstream, product data only upstream
  assign sel_ctrl = !UPSTREAM && (cfg_addr[7:2] == OFS_MSI_CTRL[7:2]); // RULE_19
  assign sel_low = !UPSTREAM && (cfg_addr[7:2] == OFS_MSI_LOW[7:2]); // RULE_19
  assign sel_high = !UPSTREAM && (cfg_addr[7:2] == OFS_MSI_HIGH[7:2]); // RULE_19
  assign sel_data = !UPSTREAM && (cfg_addr[7:2] == OFS_MSI_DATA[7:2]); // RULE_19
  assign sel_cmd = UPSTREAM && (cfg_addr[7:2] == OFS_PD_CMD[7:2]); // RULE_20
  assign sel_win = UPSTREAM && (cfg_addr[7:2] == OFS_PD_WIN[7:2]); // RULE_20
  assign sel_vnd = cfg_addr[7:2] == OFS_VND[7:2];
  assign wr = cfg_req && cfg_write;
  assign engine_busy = start_req || (state != EE_IDLE);
  // a command write on the top byte lane starts a table cycle only while idle
  assign cmd_start = wr && sel_cmd && cfg_be[3] && !engine_busy;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // message capability registers

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      interrupt_message_permit <= MSI_EN_RST; // RULE_01
      msi_mme <= MME_RST;
    end else if (wr && sel_ctrl && cfg_be[2]) begin
      interrupt_message_permit <= cfg_wdata[MSI_EN_BIT];
      msi_mme <= cfg_wdata[MME_LSB +: 3];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msi_low_target <= MSI_LOW_RST;
    end else if (wr && sel_low) begin
      // low two bits stay zero so the target is dword aligned
      msi_low_target <= merge_be(msi_low_target, {cfg_wdata[31:2], 2'b00}, cfg_be); // RULE_04
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msi_high_target <= MSI_HIGH_RST; // RULE_05
    end else if (wr && sel_high) begin
      msi_high_target <= merge_be(msi_high_target, cfg_wdata, cfg_be);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msi_payload <= MSI_DATA_RST;
    end else if (wr && sel_data) begin
      // only the low two byte lanes carry the payload
      if (cfg_be[0]) begin
        msi_payload[7:0] <= cfg_wdata[7:0];
      end
      if (cfg_be[1]) begin
        msi_payload[15:8] <= cfg_wdata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt signalling

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq_prev <= 1'b0;
    end else begin
      irq_prev <= irq_level;
    end
  end

  // legacy pin released whenever messages are permitted
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      intx_assert <= 1'b0;
    end else begin
      intx_assert <= !UPSTREAM && irq_level && !interrupt_message_permit; // RULE_02
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      msi_valid <= 1'b0;
      msi_addr <= 64'h0000_0000_0000_0000;
      msi_data <= 16'h0000;
    end else if (!interrupt_message_permit) begin
      msi_valid <= 1'b0; // RULE_01
    end else if (msi_valid) begin
      if (msi_ready) begin
        msi_valid <= 1'b0;
      end
    end else if (!UPSTREAM && irq_level && !irq_prev) begin
      msi_valid <= 1'b1; // RULE_02
      msi_addr <= {msi_high_target, msi_low_target[31:2], 2'b00}; // RULE_05 RULE_06
      msi_data <= msi_payload; // RULE_06
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product-data command and window

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      table_dword_index <= PD_INDEX_RST;
    end else if (wr && sel_cmd && cfg_be[2] && !engine_busy) begin
      table_dword_index <= cfg_wdata[PD_INDEX_LSB +: 6]; // RULE_07
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_req <= 1'b0;
    end else begin
      start_req <= cmd_start; // RULE_08 RULE_09
    end
  end

  // the flag holds the written value for the whole cycle, then inverts
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      table_cycle_flag <= PD_FLAG_RST;
    end else if (state == EE_FINISH) begin
      table_cycle_flag <= !table_cycle_flag; // RULE_08 RULE_09
    end else if (cmd_start) begin
      table_cycle_flag <= cfg_wdata[PD_FLAG_BIT];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      table_data_window <= PD_WIN_RST;
    end else if (state == EE_FINISH && !table_cycle_flag) begin
      table_data_window <= rx_shift; // RULE_11
    end else if (wr && sel_win && !engine_busy) begin
      table_data_window <= merge_be(table_data_window, cfg_wdata, cfg_be); // RULE_12 RULE_10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial EEPROM engine

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      miso_s3 <= 1'b0;
      miso_clean <= 1'b0;
    end else begin
      miso_s1 <= ee_miso;
      miso_s2 <= miso_s1;
      miso_s3 <= miso_s2;
      if (miso_s2 == miso_s3) begin
        miso_clean <= miso_s3;
      end
    end
  end

  // one frame is 48 bits, each a low then a high half of SCK_HALF clocks
  assign launch = (state == EE_IDLE) && start_req;
  assign half_done = (state == EE_SHIFT) && (phase == HALF_LAST);
  assign sck_fall = half_done && ee_sck;
  assign last_fall = sck_fall && (bit_cnt == EE_LAST_BIT);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= EE_IDLE;
    end else begin
      case (state)
        EE_IDLE: begin
          if (start_req) begin
            state <= EE_SHIFT;
          end
        end
        EE_SHIFT: begin
          if (last_fall) begin
            state <= EE_FINISH;
          end
        end
        EE_FINISH: begin
          state <= EE_IDLE;
        end
        default: begin
          state <= EE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase <= 16'h0000;
    end else if (launch || half_done) begin
      phase <= 16'h0000;
    end else if (state == EE_SHIFT) begin
      phase <= phase + 16'h0001;
    end
  end

  // serial clock idles low and toggles at the end of every half period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ee_sck <= 1'b0;
    end else if (launch) begin
      ee_sck <= 1'b0;
    end else if (half_done) begin
      ee_sck <= !ee_sck;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ee_cs_n <= 1'b1;
    end else if (launch) begin
      ee_cs_n <= 1'b0;
    end else if (last_fall) begin
      ee_cs_n <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_cnt <= 6'h00;
    end else if (launch) begin
      bit_cnt <= 6'h00;
    end else if (sck_fall && !last_fall) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // data out changes on the falling edge so it is steady at the next rise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_shift <= 48'h0000_0000_0000;
      ee_mosi <= 1'b0;
    end else if (launch) begin
      // opcode, byte address from the dword index, then the data word
      tx_shift <= {table_cycle_flag ? EE_OP_WRITE : EE_OP_READ,
                   table_dword_index, 2'b00,
                   table_cycle_flag ? table_data_window : 32'h0000_0000}; // RULE_07 RULE_12
      ee_mosi <= table_cycle_flag ? EE_OP_WRITE[7] : EE_OP_READ[7];
    end else if (last_fall) begin
      ee_mosi <= 1'b0;
    end else if (sck_fall) begin
      tx_shift <= {tx_shift[46:0], 1'b0};
      ee_mosi <= tx_shift[46];
    end
  end

  // data in is taken at every falling edge; the last 32 samples form the word
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_shift <= 32'h0000_0000;
    end else if (sck_fall) begin
      rx_shift <= {rx_shift[30:0], miso_clean};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (sel_ctrl) begin
      next_rdata = {8'h00, 1'b1, msi_mme, 3'b000, interrupt_message_permit,
                    MSI_LINK, MSI_CAP_ID}; // RULE_03 RULE_15 RULE_21
    end else if (sel_low) begin
      next_rdata = {msi_low_target[31:2], 2'b00}; // RULE_04
    end else if (sel_high) begin
      next_rdata = msi_high_target;
    end else if (sel_data) begin
      next_rdata = {16'h0000, msi_payload};
    end else if (sel_cmd) begin
      next_rdata = {table_cycle_flag, 7'h00, table_dword_index, 2'b00,
                    PD_LINK, PD_CAP_ID}; // RULE_13 RULE_16
    end else if (sel_win) begin
      next_rdata = table_data_window; // RULE_11
    end else if (sel_vnd) begin
      next_rdata = {VND_LENGTH, VND_LINK, VND_CAP_ID}; // RULE_14 RULE_17 RULE_18
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cfg_ack <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_req;
      cfg_rdata <= (cfg_req && !cfg_write) ? next_rdata : 32'h0000_0000;
    end
  end

endmodule

// >>> rtl/cap_chain_pkg.sv
// constants, field positions and states for the capability chain registers
//
// Notes on behaviour
// RULE_01: interrupt messages are blocked while the message permit bit is clear; it resets clear.
// RULE_02: with the permit set, messages may be sent and the legacy pin is released.
// RULE_03: the 64-bit capable bit of the message control word always reads one.
// RULE_04: message address bits 31:2 are writable and give the target; bits 1:0 read zero.
// RULE_05: upper message address resets to zero and forms the high half of the target.
// RULE_06: a message is a memory write to the programmed address carrying the 16-bit data.
// RULE_07: the table index at bits 23:18 addresses each EEPROM table cycle.
// RULE_08: writing the cycle flag as zero starts a read; flag becomes one when done.
// RULE_09: writing the cycle flag as one starts a write; flag becomes zero when done.
// RULE_10: host loads the data window first and polls the flag before the next access.
// RULE_11: reading the data window returns the last word fetched from the table.
// RULE_12: writing the data window supplies the word written into the table.
// RULE_13: the upstream product-data structure type code reads 03h.
// RULE_14: the vendor-specific structure type code reads 09h on both ports.
// RULE_15: downstream message structure chain link reads A4h.
// RULE_16: upstream product-data structure chain link reads A4h.
// RULE_17: vendor-specific chain link points on to subsystem ids and reads C4h.
// RULE_18: vendor-specific length field at bits 31:16 reads 000Ch.
// RULE_19: message capability registers exist only in the downstream port.
// RULE_20: product-data registers and window exist only in the upstream port.
// RULE_21: downstream message structure type code reads 05h.
package cap_chain_pkg;
  localparam logic [7:0] OFS_MSI_CTRL = 8'h8C;
  localparam logic [7:0] OFS_MSI_LOW = 8'h90;
  localparam logic [7:0] OFS_MSI_HIGH = 8'h94;
  localparam logic [7:0] OFS_MSI_DATA = 8'h98;
  localparam logic [7:0] OFS_PD_CMD = 8'h9C;
  localparam logic [7:0] OFS_PD_WIN = 8'hA0;
  localparam logic [7:0] OFS_VND = 8'hA4;

  localparam logic [7:0] MSI_CAP_ID = 8'h05;
  localparam logic [7:0] MSI_LINK = 8'hA4;
  localparam logic [7:0] PD_CAP_ID = 8'h03;
  localparam logic [7:0] PD_LINK = 8'hA4;
  localparam logic [7:0] VND_CAP_ID = 8'h09;
  localparam logic [7:0] VND_LINK = 8'hC4;
  localparam logic [15:0] VND_LENGTH = 16'h000C;

  localparam int MSI_EN_BIT = 16;
  localparam int MME_LSB = 20;
  localparam int CAP64_BIT = 23;
  localparam int PD_INDEX_LSB = 18;
  localparam int PD_FLAG_BIT = 31;

  localparam logic [31:0] MSI_LOW_RST = 32'h0000_0000;
  localparam logic [31:0] MSI_HIGH_RST = 32'h0000_0000;
  localparam logic [15:0] MSI_DATA_RST = 16'h0000;
  localparam logic MSI_EN_RST = 1'b0;
  localparam logic [2:0] MME_RST = 3'h0;
  localparam logic [5:0] PD_INDEX_RST = 6'h00;
  localparam logic PD_FLAG_RST = 1'b0;
  localparam logic [31:0] PD_WIN_RST = 32'h0000_0000;

  localparam logic [7:0] EE_OP_READ = 8'h03;
  localparam logic [7:0] EE_OP_WRITE = 8'h02;
  localparam logic [5:0] EE_LAST_BIT = 6'h2F;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SCK_HALF_NS = 40;
  localparam int SCK_HALF_CYCLES = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    EE_IDLE = 2'b00,
    EE_SHIFT = 2'b01,
    EE_FINISH = 2'b11
  } ee_state_e;
endpackage

// >>> tb/cap_chain_monitor.sv
// assertion checker for the capability chain register block
`timescale 1ns/1ps
module cap_chain_monitor
  import cap_chain_pkg::*;
#(
  parameter bit UPSTREAM = 1'b0,
  parameter int unsigned SCK_HALF = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic irq_level,
  input wire logic intx_assert,
  input wire logic msi_valid,
  input wire logic [63:0] msi_addr,
  input wire logic [15:0] msi_data,
  input wire logic msi_ready,
  input wire logic ee_cs_n,
  input wire logic ee_sck,
  input wire logic ee_mosi,
  input wire logic ee_miso
);
  logic permit_q;
  wire rd = cfg_req && !cfg_write;
  wire wr = cfg_req && cfg_write;
  // shadow of the message permit bit, rebuilt from the config writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) permit_q <= 1'b0;
    else if (wr && !UPSTREAM && cfg_addr[7:2] == 6'h23 && cfg_be[2]) permit_q <= cfg_wdata[16];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_msi_gate; $rose(msi_valid) |-> $past(permit_q); endproperty
  a_msi_gate: assert property (p_msi_gate) else $error("message raised without permit");
  property p_intx_off; permit_q |=> !intx_assert; endproperty
  a_intx_off: assert property (p_intx_off) else $error("legacy pin held with permit");
  property p_intx_on; !UPSTREAM && !permit_q && irq_level |=> intx_assert; endproperty
  a_intx_on: assert property (p_intx_on) else $error("legacy pin missing");
  property p_msi_hold;
    msi_valid && !msi_ready && permit_q |=> msi_valid && $stable(msi_addr) && $stable(msi_data);
  endproperty
  a_msi_hold: assert property (p_msi_hold) else $error("message changed while pending");
  property p_absent;
    rd && (UPSTREAM ? cfg_addr[7:2] inside {[6'h23:6'h26]} : cfg_addr[7:2] inside {6'h27, 6'h28})
      |=> cfg_rdata == 32'h0000_0000;
  endproperty
  a_absent: assert property (p_absent) else $error("absent register read nonzero");
  property p_vnd; rd && cfg_addr[7:2] == 6'h29 |=> cfg_rdata == {VND_LENGTH, VND_LINK, VND_CAP_ID};
  endproperty
  a_vnd: assert property (p_vnd) else $error("vendor dword wrong");
  property p_msi_ctrl;
    rd && !UPSTREAM && cfg_addr[7:2] == 6'h23 |=> cfg_rdata[23] && cfg_rdata[15:0] == {MSI_LINK, MSI_CAP_ID};
  endproperty
  a_msi_ctrl: assert property (p_msi_ctrl) else $error("message header wrong");
  property p_ee_start;
    wr && UPSTREAM && cfg_addr[7:2] == 6'h27 && cfg_be[3] && ee_cs_n && $past(ee_cs_n)
      && $past(ee_cs_n, 2) |-> ##2 !ee_cs_n;
  endproperty
  a_ee_start: assert property (p_ee_start) else $error("table cycle not started");
  c_msi: cover property (msi_valid && msi_ready);
  c_frame: cover property ($fell(ee_cs_n));
  c_vnd: cover property (rd && cfg_addr[7:2] == 6'h29);
endmodule
bind config_capability_chain cap_chain_monitor #(.UPSTREAM(UPSTREAM), .SCK_HALF(SCK_HALF)) mon (
  .clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
  .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
  .irq_level(irq_level), .intx_assert(intx_assert), .msi_valid(msi_valid), .msi_addr(msi_addr),
  .msi_data(msi_data), .msi_ready(msi_ready), .ee_cs_n(ee_cs_n), .ee_sck(ee_sck),
  .ee_mosi(ee_mosi), .ee_miso(ee_miso));

// >>> tb/eeprom_model.sv
// behavioural serial EEPROM holding the product-data table
`timescale 1ns/1ps
module eeprom_model
  import cap_chain_pkg::*;
(
  input wire logic clock,
  input wire logic ee_cs_n,
  input wire logic ee_sck,
  input wire logic ee_mosi,
  output logic ee_miso
);
  logic [31:0] mem [64];
  logic [47:0] sh = 48'h0;
  logic [31:0] rdw = 32'h0;
  logic [6:0] cnt = 7'h00;
  logic sck_q = 1'b0;
  initial begin
    ee_miso = 1'b0;
    for (int i = 0; i < 64; i++) mem[i] = 32'hC0DE_0000 + 32'(i);
  end
  always @(posedge clock) begin
    sck_q <= ee_sck;
    if (ee_cs_n) begin
      // deselected line toggles so a stale bit never looks like data
      ee_miso <= ~ee_miso;
      cnt <= 7'h00;
      if (cnt == 7'h30 && sh[47:40] == EE_OP_WRITE) mem[sh[39:34]] <= sh[31:0];
    end else if (ee_sck && !sck_q) begin
      sh <= {sh[46:0], ee_mosi};
      cnt <= cnt + 7'h01;
      if (cnt == 7'h10) begin
        ee_miso <= mem[sh[7:2]][31];
        rdw <= {mem[sh[7:2]][30:0], 1'b0};
      end else if (cnt > 7'h10) begin
        ee_miso <= rdw[31];
        rdw <= {rdw[30:0], 1'b0};
      end
    end
  end
endmodule

// >>> tb/tb_config_capability_chain.sv
// self-checking bench for both port roles of the capability chain
`timescale 1ns/1ps
module tb_config_capability_chain
  import cap_chain_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic cfg_req = 1'b0;
  logic cfg_write = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [3:0] cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic irq_level = 1'b0;
  logic msi_ready = 1'b0;
  logic [31:0] rd_dn, rd_up;
  logic ack_dn, ack_up, intx_dn, valid_dn, cs_n, sck, mosi, miso;
  logic [63:0] msi_addr;
  logic [15:0] msi_data;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;
  config_capability_chain #(.UPSTREAM(1'b0), .SCK_HALF(6)) uut (
    .clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(rd_dn), .cfg_ack(ack_dn),
    .irq_level(irq_level), .intx_assert(intx_dn), .msi_valid(valid_dn), .msi_addr(msi_addr),
    .msi_data(msi_data), .msi_ready(msi_ready), .ee_cs_n(), .ee_sck(), .ee_mosi(), .ee_miso(1'b0));
  config_capability_chain #(.UPSTREAM(1'b1), .SCK_HALF(6)) uut_up (
    .clock(clock), .resetn(resetn), .cfg_req(cfg_req), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(rd_up), .cfg_ack(ack_up),
    .irq_level(irq_level), .intx_assert(), .msi_valid(), .msi_addr(), .msi_data(),
    .msi_ready(msi_ready), .ee_cs_n(cs_n), .ee_sck(sck), .ee_mosi(mosi), .ee_miso(miso));
  eeprom_model ee (.clock(clock), .ee_cs_n(cs_n), .ee_sck(sck), .ee_mosi(mosi), .ee_miso(miso));
  //////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one access to both ports; read data sampled in the ack cycle
  task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    cfg_req <= 1'b1;
    cfg_write <= w;
    cfg_addr <= a;
    cfg_be <= 4'hF;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_req <= 1'b0;
    #1;
    check("ack", {ack_dn, ack_up}, 2'b11);
  endtask
  task automatic t_reset;
    logic [31:0] dn [7] = '{32'h0080_A405, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h000C_C409};
    logic [31:0] up [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_A403, 32'h0, 32'h000C_C409};
    for (int i = 0; i < 7; i++) begin
      access(1'b0, 8'h8C + 8'(4 * i), 32'h0);
      check("dn_reset", rd_dn, dn[i]);
      check("up_reset", rd_up, up[i]);
    end
    access(1'b0, 8'h50, 32'h0);
    check("unmapped", {rd_dn, rd_up}, 64'h0);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    logic [7:0] a [5] = '{8'h8C, 8'h90, 8'h94, 8'h98, 8'hA4};
    logic [31:0] d [5] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1234_5678, 32'hFFFF_ABCD, 32'h0};
    logic [31:0] e [5] = '{32'h00F1_A405, 32'hFFFF_FFFC, 32'h1234_5678, 32'h0000_ABCD, 32'h000C_C409};
    for (int i = 0; i < 5; i++) access(1'b1, a[i], d[i]);
    for (int i = 0; i < 5; i++) begin
      access(1'b0, a[i], 32'h0);
      check("dn_reg", rd_dn, e[i]);
      check("up_reg", rd_up, (i == 4) ? e[i] : 32'h0);
    end
    $display("t_regs done");
  endtask
  task automatic t_msi;
    access(1'b1, 8'h8C, 32'h0);
    @(posedge clock);
    irq_level <= 1'b1;
    repeat (4) @(posedge clock);
    #1;
    check("no_msg", valid_dn, 1'b0);
    check("intx_on", intx_dn, 1'b1);
    @(posedge clock);
    irq_level <= 1'b0;
    access(1'b1, 8'h8C, 32'h0001_0000);
    repeat (2) @(posedge clock);
    #1;
    check("intx_off", intx_dn, 1'b0);
    @(posedge clock);
    irq_level <= 1'b1;
    for (int i = 0; i < 10 && valid_dn !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    check("msg_valid", valid_dn, 1'b1);
    check("msg_addr", msi_addr, 64'h1234_5678_FFFF_FFFC);
    check("msg_data", msi_data, 16'hABCD);
    repeat (3) @(posedge clock);
    #1;
    check("msg_held", valid_dn, 1'b1);
    @(posedge clock);
    msi_ready <= 1'b1;
    @(posedge clock);
    msi_ready <= 1'b0;
    @(posedge clock);
    #1;
    check("msg_taken", valid_dn, 1'b0);
    $display("t_msi done");
  endtask
  task automatic poll(input logic v);
    access(1'b0, 8'h9C, 32'h0);
    check("flag_busy", rd_up[31], !v);
    for (int i = 0; i < 400 && rd_up[31] !== v; i++) access(1'b0, 8'h9C, 32'h0);
    check("flag_done", rd_up[31], v);
    access(1'b0, 8'hA0, 32'h0);
  endtask
  task automatic t_table;
    access(1'b1, 8'hA0, 32'hDEAD_BEEF);
    access(1'b1, 8'h9C, 32'h80A8_0000);
    poll(1'b0);
    check("table_word", ee.mem[42], 32'hDEAD_BEEF);
    access(1'b1, 8'h9C, 32'h0014_0000);
    poll(1'b1);
    check("window_5", rd_up, 32'hC0DE_0005);
    access(1'b1, 8'h9C, 32'h00A8_0000);
    poll(1'b1);
    check("window_42", rd_up, 32'hDEAD_BEEF);
    access(1'b0, 8'h9C, 32'h0);
    check("command", rd_up, 32'h80A8_A403);
    $display("t_table done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    t_reset;
    t_regs;
    t_msi;
    t_table;
    end_sim;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim;
    end
  end
endmodule
